// File: rtl/upf_ctrl.sv
// Upstream port failover control with AHB-Lite register slave
`timescale 1ns/100ps
module upf_ctrl import upf_pkg::*; #(
	parameter int unsigned SWITCH_CYCLES = UPF_SWITCH_CYCLES,
	parameter int unsigned TICK_CYCLES   = UPF_TICK_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        fund_resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        strap_mode,
	input  wire logic        strap_sel,
	input  wire logic        strap_pin_en,
	input  wire logic        strap_tim_en,
	input  wire logic        upstream_select_pin,
	output logic             upstream_port,
	output logic             failover_busy
);
	//==========================================================
	// Strap capture, held only by fundamental reset
	upf_strap_t  strap;
	logic        strap_taken;
	logic        next_strap_taken;
	upf_strap_t  next_strap;

	// Straps are sampled on the first clock after fundamental release
	always_comb begin
		next_strap       = strap;
		next_strap_taken = 1'b1;
		if (!strap_taken) begin
			next_strap.mode   = strap_mode;
			next_strap.sel    = strap_sel;
			next_strap.pin_en = strap_pin_en;
			next_strap.tim_en = strap_tim_en;
		end
	end

	always_ff @(posedge hclk or negedge fund_resetn) begin
		if (!fund_resetn) begin
			strap       <= '0;
			strap_taken <= 1'b0;
		end else begin
			strap       <= next_strap;
			strap_taken <= next_strap_taken;
		end
	end

	//==========================================================
	// AHB-Lite address phase capture
	upf_aphase_t aph;
	upf_aphase_t next_aph;
	logic        wr_stat;
	logic        wr_ctrl;
	logic        wr_wdog;

	// Zero-wait slave: every phase completes in one cycle
	always_comb begin
		next_aph = aph;
		if (hready) begin
			next_aph.valid = hsel && (htrans == UPF_HTRANS_NONSEQ ||
				htrans == UPF_HTRANS_SEQ);
			next_aph.write = hwrite;
			next_aph.addr  = haddr[11:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			aph <= '0;
		else
			aph <= next_aph;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0; // Always OKAY, unmapped reads zero
	assign wr_stat = aph.valid && aph.write && aph.addr == UPF_STATUS_OFS;
	assign wr_ctrl = aph.valid && aph.write && aph.addr == UPF_CONTROL_OFS;
	assign wr_wdog = aph.valid && aph.write && aph.addr == UPF_WATCHDOG_OFS;

	//==========================================================
	// Watchdog
	logic        tick;
	logic [31:0] wdog_count;
	logic        wdog_expired;

	upf_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.hclk    (hclk),
		.hresetn (fund_resetn),
		.tick    (tick)
	);

	// Sticky count: cleared only by fundamental reset
	upf_wdog u_wdog (
		.hclk     (hclk),
		.hresetn  (fund_resetn),
		.tick     (tick),
		.load     (wr_wdog),
		.load_val (hwdata),
		.count    (wdog_count),
		.expired  (wdog_expired)
	);

	//==========================================================
	// Control register, sticky across hot resets
	logic sel;
	logic pin_en;
	logic tim_en;
	logic next_sel;
	logic next_pin_en;
	logic next_tim_en;
	logic sw_trig;

	// Fields follow the straps until software writes them
	always_comb begin
		next_sel    = strap_taken ? sel : strap.sel;
		next_pin_en = strap_taken ? pin_en : strap.pin_en;
		next_tim_en = strap_taken ? tim_en : strap.tim_en;
		if (!strap_taken) begin
			next_sel    = strap_sel;
			next_pin_en = strap_pin_en;
			next_tim_en = strap_tim_en;
		end else if (wr_ctrl) begin
			next_sel    = hwdata[UPF_SEL_BIT];
			next_pin_en = hwdata[UPF_PIN_EN_BIT];
			next_tim_en = hwdata[UPF_TIM_EN_BIT];
		end
	end

	always_ff @(posedge hclk or negedge fund_resetn) begin
		if (!fund_resetn) begin
			sel    <= 1'b0;
			pin_en <= 1'b0;
			tim_en <= 1'b0;
		end else begin
			sel    <= next_sel;
			pin_en <= next_pin_en;
			tim_en <= next_tim_en;
		end
	end

	// Only a change of value counts as a software request
	assign sw_trig = wr_ctrl && hwdata[UPF_SEL_BIT] != sel;

	//==========================================================
	// Changeover sequencer
	typedef enum logic [1:0] {UPF_IDLE, UPF_SWITCH, UPF_FINISH} upf_state_t;
	upf_state_t  state;
	upf_state_t  next_state;
	logic [15:0] sw_cnt;
	logic [15:0] next_sw_cnt;
	logic        cur;
	logic        next_cur;
	logic        target;
	logic        next_target;
	logic        trig;
	logic        start;

	// Triggers are ignored without strapped failover mode
	assign trig = strap.mode && strap_taken && (
		sw_trig ||
		(pin_en && upstream_select_pin != cur) ||
		(tim_en && wdog_expired));
	assign start = trig && state == UPF_IDLE;

	// Target: software value, else the other port
	always_comb begin
		next_state  = state;
		next_sw_cnt = sw_cnt;
		next_cur    = strap_taken ? cur : strap_sel;
		next_target = target;
		case (state)
			UPF_IDLE: begin
				if (start) begin
					next_target = sw_trig ? hwdata[UPF_SEL_BIT] :
						(pin_en && upstream_select_pin != cur) ?
						upstream_select_pin : ~cur;
					next_sw_cnt = 16'(SWITCH_CYCLES - 1);
					next_state  = UPF_SWITCH;
				end
			end
			UPF_SWITCH: begin
				if (sw_cnt == 16'h0000) begin
					next_cur   = target;
					next_state = UPF_FINISH;
				end else
					next_sw_cnt = sw_cnt - 16'h0001;
			end
			UPF_FINISH: next_state = UPF_IDLE;
			default:    next_state = UPF_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state  <= UPF_IDLE;
			sw_cnt <= 16'h0000;
			target <= 1'b0;
		end else begin
			state  <= next_state;
			sw_cnt <= next_sw_cnt;
			target <= next_target;
		end
	end

	// Current port survives hot reset like the fields
	always_ff @(posedge hclk or negedge fund_resetn) begin
		if (!fund_resetn)
			cur <= 1'b0;
		else
			cur <= next_cur;
	end

	//==========================================================
	// Sticky status flags, set wins over write-one clear
	logic done_flag;
	logic start_flag;
	logic next_done_flag;
	logic next_start_flag;

	always_comb begin
		next_done_flag  = done_flag;
		next_start_flag = start_flag;
		if (wr_stat && hwdata[UPF_DONE_BIT])
			next_done_flag = 1'b0;
		if (wr_stat && hwdata[UPF_START_BIT])
			next_start_flag = 1'b0;
		if (state == UPF_FINISH)
			next_done_flag = 1'b1;
		if (start)
			next_start_flag = 1'b1;
	end

	always_ff @(posedge hclk or negedge fund_resetn) begin
		if (!fund_resetn) begin
			done_flag  <= 1'b0;
			start_flag <= 1'b0;
		end else begin
			done_flag  <= next_done_flag;
			start_flag <= next_start_flag;
		end
	end

	//==========================================================
	// Read data, registered in the data phase
	logic [31:0] next_hrdata;

	always_comb begin
		next_hrdata = 32'h0;
		if (hready && hsel && !hwrite && htrans[1]) begin
			case (haddr[11:0])
				UPF_STATUS_OFS: begin
					next_hrdata[UPF_MODE_BIT]  = strap.mode;
					next_hrdata[UPF_CUR_BIT]   = cur;
					next_hrdata[UPF_DONE_BIT]  = done_flag;
					next_hrdata[UPF_START_BIT] = start_flag;
				end
				UPF_CONTROL_OFS: begin
					// Last written value while switching, else current
					next_hrdata[UPF_SEL_BIT] = (state == UPF_IDLE) ?
						cur : sel;
					next_hrdata[UPF_PIN_EN_BIT] = pin_en;
					next_hrdata[UPF_TIM_EN_BIT] = tim_en;
				end
				UPF_WATCHDOG_OFS: next_hrdata = wdog_count;
				default: next_hrdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else
			hrdata <= next_hrdata;
	end

	assign upstream_port = cur; // 0: port 0/A, 1: port 2/B
	assign failover_busy = state != UPF_IDLE;
endmodule : upf_ctrl

// File: rtl/upf_pkg.sv
// Package of constants and types for the upstream port failover block
//==============================================================
// Notes on behaviour
// - Status bit 0 is set only when the strapped mode supports failover.
// - Status bit 1 shows current upstream: 0 port A, 1 port B.
// - Status bit 2 sets when a changeover completes; write one clears.
// - Status bit 3 sets when a changeover starts; write one clears.
// - A write that changes control bit 0 starts a failover.
// - Select reads current upstream, or last written value during failover.
// - Select 0 picks port 0 as upstream, 1 picks port 2.
// - Select and enables do nothing unless failover mode was strapped.
// - With bit 1 set, pin level differing from current starts failover.
// - With bit 2 set, watchdog reaching zero starts failover.
// - 32-bit watchdog drops one each microsecond, holds at zero.
//==============================================================
package upf_pkg;
	localparam logic [11:0] UPF_STATUS_OFS   = 12'h470;
	localparam logic [11:0] UPF_CONTROL_OFS  = 12'h474;
	localparam logic [11:0] UPF_WATCHDOG_OFS = 12'h478;
	localparam int unsigned UPF_MODE_BIT     = 0;
	localparam int unsigned UPF_CUR_BIT      = 1;
	localparam int unsigned UPF_DONE_BIT     = 2;
	localparam int unsigned UPF_START_BIT    = 3;
	localparam int unsigned UPF_SEL_BIT      = 0;
	localparam int unsigned UPF_PIN_EN_BIT   = 1;
	localparam int unsigned UPF_TIM_EN_BIT   = 2;
	localparam logic [31:0] UPF_WDOG_RESET   = 32'h0;
	// Clock rate and microsecond tick
	localparam int unsigned UPF_CLK_HZ       = 20000000;
	localparam int unsigned UPF_TICK_NS      = 1000;
	localparam int unsigned UPF_TICK_CYCLES  =
		UPF_TICK_NS / (1000000000 / UPF_CLK_HZ);
	// Default changeover duration in clock cycles
	localparam int unsigned UPF_SWITCH_CYCLES = 8;
	// AHB-Lite constants
	localparam logic [1:0]  UPF_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  UPF_HTRANS_SEQ    = 2'h3;
	// Strap set caught at fundamental reset
	typedef struct packed {
		logic mode;
		logic sel;
		logic pin_en;
		logic tim_en;
	} upf_strap_t;
	// Latched AHB address phase
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} upf_aphase_t;
endpackage : upf_pkg

// File: rtl/upf_tick.sv
// Microsecond tick generator for the failover watchdog
`timescale 1ns/100ps
module upf_tick import upf_pkg::*; #(
	parameter int unsigned CYCLES = UPF_TICK_CYCLES
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	output logic      tick
);
	//==========================================================
	// Divider
	logic [15:0] cnt;
	logic [15:0] next_cnt;

	// Wrap at CYCLES - 1, so the period is CYCLES clocks
	always_comb begin
		if (cnt == 16'(CYCLES - 1))
			next_cnt = 16'h0000;
		else
			next_cnt = cnt + 16'h0001;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= 16'h0000;
		else
			cnt <= next_cnt;
	end

	assign tick = (cnt == 16'(CYCLES - 1));
endmodule : upf_tick

// File: rtl/upf_wdog.sv
// Failover watchdog countdown register
`timescale 1ns/100ps
module upf_wdog import upf_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [31:0] load_val,
	output logic [31:0]      count,
	output logic             expired
);
	//==========================================================
	// Countdown
	logic [31:0] next_count;

	// Software load wins over the tick; zero holds
	always_comb begin
		next_count = count;
		if (load)
			next_count = load_val;
		else if (tick && count != 32'h0)
			next_count = count - 32'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count <= UPF_WDOG_RESET;
		else
			count <= next_count;
	end

	// One-cycle pulse on the one-to-zero step only
	assign expired = !load && tick && count == 32'h1;
endmodule : upf_wdog

// File: dv/upf_pin_model.sv
// Model of the external upstream-select pin source
`timescale 1ns/100ps
module upf_pin_model (
	input  wire logic hclk,
	input  wire logic level,
	output logic      upstream_select_pin
);
	//==============================================================
	// Pin driver
	// Pin moves only after an edge, like a synchronous board signal
	always_ff @(posedge hclk) begin
		upstream_select_pin <= level;
	end
endmodule : upf_pin_model

// File: dv/upf_ctrl_props.sv
// Checker for the failover control block, seen from its ports
`timescale 1ns/100ps
module upf_ctrl_props #(
	parameter int unsigned SWITCH_CYCLES = 8
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        fund_resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        strap_mode,
	input wire logic        upstream_port,
	input wire logic        failover_busy
);
	//==============================================================
	// Helpers
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!(hresetn && fund_resetn));
	logic        rd;
	logic [7:0]  blen;
	assign rd = hsel && hready && htrans[1] && !hwrite;
	// Busy length counter, cleared whenever idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) blen <= 8'h00;
		else if (failover_busy) blen <= blen + 8'h01;
		else blen <= 8'h00;
	end
	//==============================================================
	// Properties
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave stalled or erred");
	a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	a_status_read: assert property (
		$past(rd && haddr[11:0] == 12'h470) |->
		hrdata[31:4] == 28'h0 && hrdata[0] == strap_mode &&
		hrdata[1] == $past(upstream_port))
		else $error("status read wrong");
	a_ctrl_read: assert property (
		$past(rd && haddr[11:0] == 12'h474 && !failover_busy) |->
		hrdata[0] == $past(upstream_port))
		else $error("select read differs from current port");
	a_busy_mode: assert property ($rose(failover_busy) |-> strap_mode)
		else $error("failover without capable mode");
	a_no_mode: assert property (!strap_mode |-> !failover_busy)
		else $error("busy while mode off");
	// Skip the strap load of the port, two edges after fundamental release
	a_port_move: assert property ($past(fund_resetn, 2) &&
		$changed(upstream_port) |-> failover_busy)
		else $error("port changed outside failover");
	a_busy_len: assert property ($fell(failover_busy) |->
		blen == SWITCH_CYCLES + 1)
		else $error("changeover length wrong");
	c_fail: cover property ($rose(failover_busy));
	c_port_b: cover property ($rose(upstream_port));
	c_stat_rd: cover property (rd && haddr[11:0] == 12'h470);
endmodule : upf_ctrl_props
bind upf_ctrl upf_ctrl_props #(.SWITCH_CYCLES(SWITCH_CYCLES)) i_props (
	.hclk, .hresetn, .fund_resetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .strap_mode, .upstream_port,
	.failover_busy);

// File: dv/upstream_port_failover_ctrl_tb.sv
// Self-checking bench for the failover control block
`timescale 1ns/100ps
module upstream_port_failover_ctrl_tb;
	import upf_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, fund_resetn = 1'b0;
	logic        hsel = 1'b0, hwrite = 1'b0, strap_mode = 1'b1;
	logic        pin_lvl = 1'b0;
	logic        strap_sel = 1'b0, strap_pin_en = 1'b0;
	logic        strap_tim_en = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv;
	logic [1:0]  htrans = 2'h0;
	wire  logic  hready, pin, upstream_port, failover_busy, hresp;
	wire  logic [31:0] hrdata;
	int          fails = 0, cmp_count = 0, cyc = 0;
	//==============================================================
	// Clock, timeout and instances
	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	upf_ctrl #(.SWITCH_CYCLES(3), .TICK_CYCLES(2)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .fund_resetn(fund_resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .strap_mode(strap_mode),
		.strap_sel(strap_sel), .strap_pin_en(strap_pin_en),
		.strap_tim_en(strap_tim_en),
		.upstream_select_pin(pin), .upstream_port(upstream_port),
		.failover_busy(failover_busy));
	upf_pin_model i_pin (.hclk(hclk), .level(pin_lvl),
		.upstream_select_pin(pin));
	//==============================================================
	// Shared tasks
	task chk(input string n, input logic [31:0] got, input logic [31:0] ex);
		cmp_count++;
		if (got !== ex) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, ex, got);
		end
	endtask : chk
	// One single transfer; waits on hready, never a fixed count
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rdv = hrdata;
	endtask : ahb
	task rd(input string n, input logic [11:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h0);
		chk(n, rdv, ex);
	endtask : rd
	// Bounded wait for one whole changeover
	task wait_fo();
		int i;
		i = 0;
		while (failover_busy !== 1'b1 && i < 60) begin
			@(posedge hclk);
			i++;
		end
		while (failover_busy !== 1'b0 && i < 60) begin
			@(posedge hclk);
			i++;
		end
		chk("changeover seen", i < 60, 1'b1);
	endtask : wait_fo
	task do_reset(input logic fund);
		hresetn <= 1'b0;
		if (fund) fund_resetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		fund_resetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask : do_reset
	task give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	//==============================================================
	// Scenarios
	task t_reset();
		rd("status", 12'h470, 32'h1);
		rd("control", 12'h474, 32'h0);
		rd("unmapped", 12'h47C, 32'h0);
		$display("t_reset done");
	endtask : t_reset
	task t_sw();
		ahb(1'b1, 12'h474, 32'h1);
		rd("ctrl in flight", 12'h474, 32'h1);
		wait_fo();
		chk("port b", upstream_port, 1'b1);
		rd("status done", 12'h470, 32'hF);
		ahb(1'b1, 12'h470, 32'hC);
		rd("status cleared", 12'h470, 32'h3);
		ahb(1'b1, 12'h474, 32'h1);
		repeat (6) @(posedge hclk);
		rd("same sel no start", 12'h470, 32'h3);
		$display("t_sw done");
	endtask : t_sw
	task t_pin();
		pin_lvl <= 1'b1;
		ahb(1'b1, 12'h474, 32'h3);
		pin_lvl <= 1'b0;
		wait_fo();
		chk("pin port", upstream_port, 1'b0);
		rd("pin status", 12'h470, 32'hD);
		// Idle select reads the current port, not the stored 1
		rd("ctrl idle cur", 12'h474, 32'h2);
		// Stored select differs, so this write starts a changeover
		ahb(1'b1, 12'h474, 32'h0);
		wait_fo();
		chk("sw port 0", upstream_port, 1'b0);
		ahb(1'b1, 12'h470, 32'hC);
		rd("pin cleared", 12'h470, 32'h1);
		$display("t_pin done");
	endtask : t_pin
	task t_tim();
		ahb(1'b1, 12'h474, 32'h4);
		ahb(1'b1, 12'h478, 32'h3);
		wait_fo();
		chk("timer port", upstream_port, 1'b1);
		rd("watchdog held", 12'h478, 32'h0);
		rd("timer status", 12'h470, 32'hF);
		$display("t_tim done");
	endtask : t_tim
	task t_hot();
		do_reset(1'b0);
		rd("ctrl kept", 12'h474, 32'h5);
		// New straps: mode off, port 2, both triggers on
		strap_mode <= 1'b0;
		strap_sel <= 1'b1;
		strap_pin_en <= 1'b1;
		strap_tim_en <= 1'b1;
		do_reset(1'b1);
		rd("mode off", 12'h470, 32'h2);
		rd("strap ctrl", 12'h474, 32'h7);
		// Pin mismatch, select change and expiry must all be ignored
		ahb(1'b1, 12'h474, 32'h6);
		ahb(1'b1, 12'h478, 32'h1);
		repeat (8) @(posedge hclk);
		chk("no failover", upstream_port, 1'b1);
		chk("never busy", failover_busy, 1'b0);
		$display("t_hot done");
	endtask : t_hot
	//==============================================================
	// Main sequence
	initial begin
		do_reset(1'b1);
		t_reset();
		t_sw();
		t_pin();
		t_tim();
		t_hot();
		give_verdict();
	end
endmodule : upstream_port_failover_ctrl_tb
